// ---- rtl/motion_feature_config_regs.sv ----
// Motion-feature configuration bank with axis remap and wake-on-motion compare.
module motion_feature_config_regs (
  input wire logic ref_clk_i,                          // 200 MHz clock
  input wire logic resetn_i,                           // Synchronous reset, active low
  input wire logic ce_i,                               // Clock enable, freezes all state
  input wire logic reg_wr_i,                           // Register write strobe
  input wire logic reg_rd_i,                           // Register read strobe
  input wire logic [motion_cfg_pkg::ADDR_W-1:0] reg_addr_i,  // Register address
  input wire logic [motion_cfg_pkg::DATA_W-1:0] reg_wdata_i, // Write data
  output logic [motion_cfg_pkg::DATA_W-1:0] reg_rdata_o,     // Read data
  output logic reg_rvalid_o,                           // Read data valid pulse
  input wire logic accel_valid_i,                      // Chip-frame sample valid
  input motion_cfg_pkg::axes_t accel_i,                // Chip-frame sample
  input motion_cfg_pkg::full_scale_t full_scale_i,     // Accelerometer full scale
  input wire logic rate_25hz_i,                        // Output rate is 25 Hz, else 50 Hz up
  output motion_cfg_pkg::axes_t dev_accel_o,           // Device-frame sample
  output logic dev_valid_o,                            // Device-frame sample valid
  output logic [2:0] motion_wake_o,                    // Z,Y,X wake decision pulse
  output logic [3:0] tilt_wait_s_o,                    // Tilt delay in seconds
  output logic [10:0] sleep_timeout_cs_o,              // Sleep timeout, 10 ms units
  output logic [8:0] gesture_window_cs_o,              // Gesture window, 10 ms units
  output motion_cfg_pkg::tap_cfg_t tap_cfg_o,          // Tap tuning fields
  output motion_cfg_pkg::ped_mode_t ped_mode_o         // Pedometer mode
);
  import motion_cfg_pkg::*;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic [NREG-1:0] decode(input logic [ADDR_W-1:0] a);
    decode = '0;
    for (int i = 0; i < NREG; i++) begin
      if (a == REG_OFS[i]) begin
        decode[i] = 1'b1;
      end
    end
  endfunction

  logic [NREG-1:0] sel;
  logic [DATA_W-1:0] cfg_r [NREG];
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] reg_rdata_r;
  logic reg_rvalid_r;

  assign sel = decode(reg_addr_i);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  // Reserved bits are stored like the rest, so a read-modify-write keeps them.
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
        cfg_r[g] <= REG_RST[g];
      end else if (ce_i && reg_wr_i && sel[g]) begin
        cfg_r[g] <= reg_wdata_i;
      end
    end
  end

  always_comb begin
    rd_mux = RDATA_UNMAPPED;
    for (int i = 0; i < NREG; i++) begin
      if (sel[i]) begin
        rd_mux = cfg_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_r <= RDATA_UNMAPPED;
      reg_rvalid_r <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_r <= rd_mux;
      end
    end
  end

  assign reg_rdata_o = reg_rdata_r;
  assign reg_rvalid_o = reg_rvalid_r;

  // ==========================================================================
  // Field decode
  // ==========================================================================
  wire [1:0] tilt_code = cfg_r[IDX_TILT_SLEEP][TILT_WAIT_LSB +: 2];
  wire [2:0] sleep_code = cfg_r[IDX_TILT_SLEEP][SLEEP_TO_LSB +: 3];
  wire [2:0] mount_code = cfg_r[IDX_MOUNT][MOUNT_LSB +: 3];
  wire [2:0] gesture_code = cfg_r[IDX_GESTURE][GESTURE_LSB +: 3];
  wire sens_bit = cfg_r[IDX_STEP_SENS][SENS_BIT];

  wire [3:0] tilt_nxt = 4'(tilt_code) * TILT_STEP_S;
  wire [10:0] sleep_nxt = (11'(sleep_code) + 11'h001) * SLEEP_STEP_CS;
  wire [8:0] gesture_nxt = (9'(gesture_code) + 9'h001) * GESTURE_STEP_CS;

  tap_cfg_t tap_nxt;
  assign tap_nxt.jerk_floor = cfg_r[IDX_TAP_JERK][JERK_LSB +: 6];
  assign tap_nxt.peak_tolerance = cfg_r[IDX_TAP_JERK][PEAK_LSB +: 2];
  assign tap_nxt.measure_window = cfg_r[IDX_TAP_WIN][TMEAS_LSB +: 2];
  assign tap_nxt.energy_window = cfg_r[IDX_TAP_WIN][TENERGY_LSB +: 2];
  assign tap_nxt.single_window = cfg_r[IDX_TAP_WIN][TSINGLE_LSB +: 3];

  ped_mode_t ped_nxt;
  assign ped_nxt = sens_bit ? (rate_25hz_i ? PED_LP_SLOW_WALK : PED_SLOW_WALK)
                            : (rate_25hz_i ? PED_LOW_POWER : PED_HIGH_PERF);

  logic [3:0] tilt_r;
  logic [10:0] sleep_r;
  logic [8:0] gesture_r;
  tap_cfg_t tap_r;
  ped_mode_t ped_r;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tilt_r <= '0;
      sleep_r <= '0;
      gesture_r <= '0;
      tap_r <= '0;
      ped_r <= PED_LOW_POWER;
    end else if (ce_i) begin
      tilt_r <= tilt_nxt;
      sleep_r <= sleep_nxt;
      gesture_r <= gesture_nxt;
      tap_r <= tap_nxt;
      ped_r <= ped_nxt;
    end
  end

  assign tilt_wait_s_o = tilt_r;
  assign sleep_timeout_cs_o = sleep_r;
  assign gesture_window_cs_o = gesture_r;
  assign tap_cfg_o = tap_r;
  assign ped_mode_o = ped_r;

  // ==========================================================================
  // Axis remap and wake-on-motion
  // ==========================================================================
  axes_t remap;
  axes_t dev_r;
  logic dev_valid_r;
  logic prev_ok_r;
  logic [2:0] wake_r;
  logic [2:0] wake_nxt;

  axis_remap u_remap (
    .mount_i(mount_code),
    .chip_i(accel_i),
    .dev_o(remap)
  );

  wire [2:0] wake_shift = WAKE_SHIFT_BASE - {1'b0, full_scale_i};
  wire signed [15:0] cur_ax [3];
  wire signed [15:0] prev_ax [3];
  wire [DATA_W-1:0] thr_ax [3];
  assign cur_ax = '{remap.x, remap.y, remap.z};
  assign prev_ax = '{dev_r.x, dev_r.y, dev_r.z};
  assign thr_ax = '{cfg_r[IDX_WAKE_X], cfg_r[IDX_WAKE_Y], cfg_r[IDX_WAKE_Z]};

  // The change between samples is scaled to 1g/256 units before comparing, so the
  // threshold means the same acceleration on every full scale.
  for (genvar a = 0; a < 3; a++) begin : g_wake
    wire signed [16:0] delta = {cur_ax[a][15], cur_ax[a]} - {prev_ax[a][15], prev_ax[a]};
    wire [16:0] mag = delta[16] ? 17'(-delta) : 17'(delta);
    wire [16:0] scaled = mag >> wake_shift;
    assign wake_nxt[a] = prev_ok_r && (scaled > {9'h000, thr_ax[a]});
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      dev_r <= '0;
      dev_valid_r <= 1'b0;
      prev_ok_r <= 1'b0;
      wake_r <= '0;
    end else if (ce_i) begin
      dev_valid_r <= accel_valid_i;
      wake_r <= accel_valid_i ? wake_nxt : 3'h0;
      if (accel_valid_i) begin
        dev_r <= remap;
        prev_ok_r <= 1'b1;
      end
    end
  end

  assign dev_accel_o = dev_r;
  assign dev_valid_o = dev_valid_r;
  assign motion_wake_o = {wake_r[2], wake_r[1], wake_r[0]};

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_write(logic [ADDR_W-1:0] ad);
    ce_i && reg_wr_i && reg_addr_i == ad;
  endsequence

  sequence s_read(logic [ADDR_W-1:0] ad);
    ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == ad;
  endsequence

  a_reset_value_load: assert property (@(posedge ref_clk_i)
    !resetn_i |=> cfg_r[IDX_TILT_SLEEP] == 8'ha4 && cfg_r[IDX_MOUNT] == 8'h8c
      && cfg_r[IDX_TAP_WIN] == 8'h5b)
    else $error("register reset value wrong");

  a_write_read_back: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_write(OFS_TAP_JERK_AND_PEAK) ##1 s_read(OFS_TAP_JERK_AND_PEAK)
      |=> reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("read back differs from written byte");

  a_unmapped_read_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && reg_rd_i && sel == '0 |=> reg_rvalid_o && reg_rdata_o == RDATA_UNMAPPED)
    else $error("unmapped read not zero");

  a_tilt_wait_map: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && tilt_code == 2'h3 |=> tilt_wait_s_o == 4'h6)
    else $error("tilt wait decode wrong");

  a_sleep_timeout_map: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && sleep_code == 3'h7 |=> sleep_timeout_cs_o == 11'h400)
    else $error("sleep timeout decode wrong");

  a_gesture_window_map: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i |=> gesture_window_cs_o == 9'h020 * (9'($past(gesture_code)) + 9'h001))
    else $error("gesture window decode wrong");

  a_ped_mode_select: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && !sens_bit && !rate_25hz_i |=> ped_mode_o == PED_HIGH_PERF)
    else $error("pedometer mode wrong with bit clear");

  a_ped_slow_walk: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && sens_bit && rate_25hz_i |=> ped_mode_o == PED_LP_SLOW_WALK)
    else $error("pedometer mode wrong with bit set");

  a_remap_swap_axes: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && accel_valid_i && mount_code == 3'h4 |=> dev_valid_o
      && dev_accel_o.x == $past(accel_i.y) && dev_accel_o.y == $past(accel_i.x))
    else $error("swap mounting code remaps wrong");

  a_remap_pass_through: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && accel_valid_i && mount_code == 3'h0 |=> dev_accel_o == $past(accel_i))
    else $error("identity mounting code alters sample");

  a_wake_needs_sample: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    motion_wake_o != 3'h0 |-> dev_valid_o && $past(prev_ok_r))
    else $error("wake raised without a sample");

  a_wake_zero_thresh: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && accel_valid_i && prev_ok_r && thr_ax[0] == 8'h00 && full_scale_i == FS_2G
      && cur_ax[0] - prev_ax[0] > 16'sh0040 && cur_ax[0] > prev_ax[0]
      && prev_ax[0] >= 16'sh0000 |=> motion_wake_o[0])
    else $error("x wake missed above threshold");

  a_clock_enable_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !ce_i |=> $stable(dev_accel_o) && $stable(reg_rdata_o) && $stable(tilt_wait_s_o))
    else $error("state changed while clock enable low");

  a_read_valid_pulse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && !reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without a read");

  a_tap_window_fields: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i |=> tap_cfg_o.measure_window == $past(cfg_r[IDX_TAP_WIN][TMEAS_LSB +: 2])
      && tap_cfg_o.energy_window == $past(cfg_r[IDX_TAP_WIN][TENERGY_LSB +: 2])
      && tap_cfg_o.single_window == $past(cfg_r[IDX_TAP_WIN][TSINGLE_LSB +: 3]))
    else $error("tap window fields not copied");

  a_remap_negate_xy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && accel_valid_i && mount_code == 3'h3 && accel_i.x != 16'sh8000
      && accel_i.y != 16'sh8000 |=> dev_accel_o.x == -$past(accel_i.x)
      && dev_accel_o.y == -$past(accel_i.y) && dev_accel_o.z == $past(accel_i.z))
    else $error("mounting code three remaps wrong");

  a_wake_y_scaled: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && accel_valid_i && prev_ok_r && full_scale_i == FS_16G && prev_ax[1] >= 16'sh0000
      && cur_ax[1] > prev_ax[1] && cur_ax[1] - prev_ax[1] >= {5'h00, thr_ax[1], 3'h0} + 16'h0008
      |=> motion_wake_o[1])
    else $error("y wake missed on the 16 g range");

  a_wake_z_still: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i && accel_valid_i && cur_ax[2] == prev_ax[2] |=> !motion_wake_o[2])
    else $error("z wake with no z change");

  a_dev_valid_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    ce_i |=> dev_valid_o == $past(accel_valid_i))
    else $error("device sample valid out of step");

endmodule

// ---- rtl/motion_cfg_pkg.sv ----
// Package holding offsets, reset values, field layouts and types of the motion-feature bank.
package motion_cfg_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NREG = 9;

  localparam int IDX_TILT_SLEEP = 0;
  localparam int IDX_MOUNT = 1;
  localparam int IDX_GESTURE = 2;
  localparam int IDX_TAP_JERK = 3;
  localparam int IDX_TAP_WIN = 4;
  localparam int IDX_STEP_SENS = 5;
  localparam int IDX_WAKE_X = 6;
  localparam int IDX_WAKE_Y = 7;
  localparam int IDX_WAKE_Z = 8;

  localparam logic [ADDR_W-1:0] OFS_TILT_AND_SLEEP_TIMING = 8'h43;
  localparam logic [ADDR_W-1:0] OFS_AXIS_MOUNTING_SELECT = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_GESTURE_WINDOW = 8'h45;
  localparam logic [ADDR_W-1:0] OFS_TAP_JERK_AND_PEAK = 8'h46;
  localparam logic [ADDR_W-1:0] OFS_TAP_SAMPLE_WINDOWS = 8'h47;
  localparam logic [ADDR_W-1:0] OFS_STEP_SENSITIVITY_SELECT = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_MOTION_WAKE_THRESH_X = 8'h4a;
  localparam logic [ADDR_W-1:0] OFS_MOTION_WAKE_THRESH_Y = 8'h4b;
  localparam logic [ADDR_W-1:0] OFS_MOTION_WAKE_THRESH_Z = 8'h4c;

  localparam logic [ADDR_W-1:0] REG_OFS [NREG] = '{
    OFS_TILT_AND_SLEEP_TIMING, OFS_AXIS_MOUNTING_SELECT, OFS_SLEEP_GESTURE_WINDOW,
    OFS_TAP_JERK_AND_PEAK, OFS_TAP_SAMPLE_WINDOWS, OFS_STEP_SENSITIVITY_SELECT,
    OFS_MOTION_WAKE_THRESH_X, OFS_MOTION_WAKE_THRESH_Y, OFS_MOTION_WAKE_THRESH_Z};

  localparam logic [DATA_W-1:0] REG_RST [NREG] = '{
    8'ha4, 8'h8c, 8'h5c, 8'h45, 8'h5b, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TILT_WAIT_LSB = 6;
  localparam int SLEEP_TO_LSB = 3;
  localparam int MOUNT_LSB = 0;
  localparam int GESTURE_LSB = 0;
  localparam int JERK_LSB = 2;
  localparam int PEAK_LSB = 0;
  localparam int TMEAS_LSB = 5;
  localparam int TENERGY_LSB = 3;
  localparam int TSINGLE_LSB = 0;
  localparam int SENS_BIT = 0;

  // ==========================================================================
  // Timing steps, in seconds and in hundredths of a second
  // ==========================================================================
  localparam logic [3:0] TILT_STEP_S = 4'h2;
  localparam logic [10:0] SLEEP_STEP_CS = 11'h080;
  localparam logic [8:0] GESTURE_STEP_CS = 9'h020;

  // A full-scale code k spans 2^(k+1) g over 2^15 counts; 1 g/256 units need >> (6-k).
  localparam logic [2:0] WAKE_SHIFT_BASE = 3'h6;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {FS_2G, FS_4G, FS_8G, FS_16G} full_scale_t;
  typedef enum logic [1:0] {PED_LOW_POWER, PED_HIGH_PERF, PED_LP_SLOW_WALK,
                            PED_SLOW_WALK} ped_mode_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } axes_t;

  typedef struct packed {
    logic [5:0] jerk_floor;
    logic [1:0] peak_tolerance;
    logic [1:0] measure_window;
    logic [1:0] energy_window;
    logic [2:0] single_window;
  } tap_cfg_t;

endpackage

// ---- rtl/axis_remap.sv ----
// Signed axis permutation from chip frame to device frame.
module axis_remap (
  input wire logic [2:0] mount_i,            // Mounting code
  input motion_cfg_pkg::axes_t chip_i,       // Chip-frame sample
  output motion_cfg_pkg::axes_t dev_o        // Device-frame sample
);
  import motion_cfg_pkg::*;

  // Negating the most negative count would wrap, so it saturates instead.
  function automatic logic signed [15:0] neg(input logic signed [15:0] v);
    neg = (v == 16'sh8000) ? 16'sh7fff : -v;
  endfunction

  always_comb begin
    case (mount_i)
      3'h0: dev_o = '{chip_i.x, chip_i.y, chip_i.z};
      3'h1: dev_o = '{chip_i.x, neg(chip_i.y), neg(chip_i.z)};
      3'h2: dev_o = '{neg(chip_i.x), chip_i.y, neg(chip_i.z)};
      3'h3: dev_o = '{neg(chip_i.x), neg(chip_i.y), chip_i.z};
      3'h4: dev_o = '{chip_i.y, chip_i.x, neg(chip_i.z)};
      3'h5: dev_o = '{chip_i.y, neg(chip_i.x), chip_i.z};
      3'h6: dev_o = '{neg(chip_i.y), chip_i.x, chip_i.z};
      default: dev_o = '{neg(chip_i.y), neg(chip_i.x), neg(chip_i.z)};
    endcase
  end

endmodule

// ---- dv/tb.sv ----
// Self-checking testbench for the motion-feature configuration bank.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import motion_cfg_pkg::*;

  // ==========================================================================
  // Stimulus and observation signals
  // ==========================================================================
  logic ref_clk_i, resetn_i, ce_i, reg_wr_i, reg_rd_i, accel_valid_i, rate_25hz_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic reg_rvalid_o, dev_valid_o;
  axes_t accel_i, dev_accel_o;
  full_scale_t full_scale_i;
  logic [2:0] motion_wake_o;
  logic [3:0] tilt_wait_s_o;
  logic [10:0] sleep_timeout_cs_o;
  logic [8:0] gesture_window_cs_o;
  tap_cfg_t tap_cfg_o;
  ped_mode_t ped_mode_o;
  int error_cnt = 0;
  int cmp_count = 0;

  motion_feature_config_regs i_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .accel_valid_i(accel_valid_i),
    .accel_i(accel_i), .full_scale_i(full_scale_i), .rate_25hz_i(rate_25hz_i),
    .dev_accel_o(dev_accel_o), .dev_valid_o(dev_valid_o), .motion_wake_o(motion_wake_o),
    .tilt_wait_s_o(tilt_wait_s_o), .sleep_timeout_cs_o(sleep_timeout_cs_o),
    .gesture_window_cs_o(gesture_window_cs_o), .tap_cfg_o(tap_cfg_o),
    .ped_mode_o(ped_mode_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Inputs always move 1 ns after the rising edge, so the design samples settled values.
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic do_reset();
    resetn_i = 1'b0;
    repeat (5) step();
    resetn_i = 1'b1;
  endtask

  // Strobes stay up between back-to-back calls; idle drops them for one cycle.
  task automatic idle();
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    accel_valid_i = 1'b0;
    step();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd_i = 1'b0;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    step();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    step();
    cmp(reg_rvalid_o, 48'h1);
    cmp(reg_rdata_o, exp);
  endtask

  task automatic smp(input axes_t s, input axes_t exp, input logic [2:0] wake);
    accel_valid_i = 1'b1;
    accel_i = s;
    step();
    cmp(dev_valid_o, 48'h1);
    cmp(dev_accel_o, exp);
    cmp(motion_wake_o, wake);
  endtask

  function automatic axes_t remap(input logic [2:0] m, input axes_t s);
    case (m)
      3'h0: return '{s.x, s.y, s.z};
      3'h1: return '{s.x, -s.y, -s.z};
      3'h2: return '{-s.x, s.y, -s.z};
      3'h3: return '{-s.x, -s.y, s.z};
      3'h4: return '{s.y, s.x, -s.z};
      3'h5: return '{s.y, -s.x, s.z};
      3'h6: return '{-s.y, s.x, s.z};
      default: return '{-s.y, -s.x, -s.z};
    endcase
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_reset_vals();
    for (int i = 0; i < NREG; i++) rd(REG_OFS[i], REG_RST[i]);
    idle();
    cmp(tilt_wait_s_o, 48'h4);
    cmp(sleep_timeout_cs_o, 48'h280);
    cmp(gesture_window_cs_o, 48'ha0);
    end_test("reset_values");
  endtask

  task automatic s_readback();
    for (int i = 0; i < NREG; i++) wr(REG_OFS[i], 8'hff - 8'(i * 17));
    wr(8'h49, 8'hff);
    rd(8'h49, RDATA_UNMAPPED);
    rd(8'h42, RDATA_UNMAPPED);
    for (int i = 0; i < NREG; i++) rd(REG_OFS[i], 8'hff - 8'(i * 17));
    // A read and a write in one cycle must hand back the old byte.
    reg_wr_i = 1'b1;
    reg_addr_i = OFS_MOTION_WAKE_THRESH_Y;
    reg_wdata_i = 8'h3c;
    step();
    cmp(reg_rdata_o, 8'h88);
    rd(OFS_MOTION_WAKE_THRESH_Y, 8'h3c);
    idle();
    end_test("readback");
  endtask

  task automatic s_decode();
    for (int i = 0; i < 8; i++) begin
      wr(OFS_TILT_AND_SLEEP_TIMING, {i[1:0], i[2:0], 3'h7});
      wr(OFS_SLEEP_GESTURE_WINDOW, {5'h1b, i[2:0]});
      idle();
      cmp(tilt_wait_s_o, 48'(i % 4) * 48'h2);
      cmp(sleep_timeout_cs_o, 48'(i + 1) * 48'h80);
      cmp(gesture_window_cs_o, 48'(i + 1) * 48'h20);
    end
    end_test("decode");
  endtask

  task automatic s_tap();
    wr(OFS_TAP_JERK_AND_PEAK, 8'h45);
    wr(OFS_TAP_SAMPLE_WINDOWS, 8'h2b);
    idle();
    cmp(tap_cfg_o, {6'h11, 2'h1, 2'h1, 2'h1, 3'h3});
    wr(OFS_TAP_SAMPLE_WINDOWS, 8'h54);
    wr(OFS_TAP_JERK_AND_PEAK, 8'hba);
    rd(OFS_TAP_JERK_AND_PEAK, 8'hba);
    idle();
    cmp(tap_cfg_o, {6'h2e, 2'h2, 2'h2, 2'h2, 3'h4});
    end_test("tap");
  endtask

  task automatic s_ped();
    ped_mode_t exp;
    for (int i = 0; i < 4; i++) begin
      rate_25hz_i = i[1];
      wr(OFS_STEP_SENSITIVITY_SELECT, {7'h55, i[0]});
      idle();
      if (i[0]) exp = i[1] ? PED_LP_SLOW_WALK : PED_SLOW_WALK;
      else exp = i[1] ? PED_LOW_POWER : PED_HIGH_PERF;
      cmp(ped_mode_o, exp);
    end
    end_test("pedometer");
  endtask

  task automatic s_ce();
    wr(OFS_MOTION_WAKE_THRESH_X, 8'h12);
    idle();
    ce_i = 1'b0;
    wr(OFS_MOTION_WAKE_THRESH_X, 8'h77);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    step();
    cmp(reg_rvalid_o, 48'h0);
    idle();
    ce_i = 1'b1;
    rd(OFS_MOTION_WAKE_THRESH_X, 8'h12);
    idle();
    end_test("clock_enable");
  endtask

  task automatic s_mount();
    axes_t s;
    s = '{16'h0100, 16'h0200, 16'h0300};
    full_scale_i = FS_2G;
    for (int i = 0; i < 3; i++) wr(REG_OFS[IDX_WAKE_X + i], 8'hff);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_AXIS_MOUNTING_SELECT, {5'h1d, m[2:0]});
      idle();
      smp(s, remap(m[2:0], s), 3'h0);
      idle();
      rd(OFS_AXIS_MOUNTING_SELECT, {5'h1d, m[2:0]});
      idle();
    end
    end_test("mounting");
  endtask

  task automatic s_wake();
    do_reset();
    full_scale_i = FS_2G;
    wr(OFS_MOTION_WAKE_THRESH_X, 8'h10);
    wr(OFS_MOTION_WAKE_THRESH_Y, 8'h20);
    wr(OFS_MOTION_WAKE_THRESH_Z, 8'h08);
    wr(OFS_AXIS_MOUNTING_SELECT, 8'h88);
    idle();
    smp('{16'h0000, 16'h0000, 16'h0000}, '{16'h0000, 16'h0000, 16'h0000}, 3'h0);
    // Differences 17, 32 and 8 in 1 g/256 units at the 2 g range.
    smp('{16'h0440, 16'h0800, 16'hfdf7}, '{16'h0440, 16'h0800, 16'hfdf7}, 3'h1);
    idle();
    full_scale_i = FS_16G;
    // Differences 16, 33 and 9 units once the range is 16 g.
    smp('{16'h04c0, 16'h0908, 16'hfe3f}, '{16'h04c0, 16'h0908, 16'hfe3f}, 3'h6);
    idle();
    cmp(dev_valid_o, 48'h0);
    cmp(motion_wake_o, 48'h0);
    // A zero threshold wakes on a change of one 1 g/256 unit or more.
    wr(OFS_MOTION_WAKE_THRESH_X, 8'h00);
    full_scale_i = FS_2G;
    idle();
    smp('{16'h0501, 16'h0908, 16'hfe3f}, '{16'h0501, 16'h0908, 16'hfe3f}, 3'h1);
    idle();
    end_test("motion_wake");
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The whole run needs well under 1000 cycles; this bound only catches a hang.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    test_done();
  end

  initial begin
    ce_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    accel_valid_i = 1'b0;
    accel_i = '0;
    full_scale_i = FS_2G;
    rate_25hz_i = 1'b1;
    do_reset();
    s_reset_vals();
    s_readback();
    s_decode();
    s_tap();
    s_ped();
    s_ce();
    s_mount();
    s_wake();
    test_done();
  end
endmodule
